//--- core/cmiu_regs.svh
/*
 * register map, control bit positions and serial framing figures of the
 * channel match interrupt unit.
 * assumes: included by bare name from each core module file.
 */
`ifndef CMIU_REGS_SVH
`define CMIU_REGS_SVH

// ---------------------------------------------------------------------
// register offsets on the parallel bus
// ---------------------------------------------------------------------
`define CMIU_ADDR_W        6
`define CMIU_OFF_CTRL1     6'h20
`define CMIU_OFF_VECTOR    6'h22
`define CMIU_OFF_FLAGS1    6'h24
`define CMIU_OFF_FLAGS2    6'h25
`define CMIU_OFF_IMAGE1    6'h26
`define CMIU_OFF_IMAGE2    6'h27
`define CMIU_OFF_MASK1     6'h28
`define CMIU_OFF_MASK2     6'h29
`define CMIU_OFF_MATCH1    6'h2A
`define CMIU_OFF_MATCH2    6'h2B
`define CMIU_OFF_SLOT1     6'h2C
`define CMIU_OFF_SLOT2     6'h2D

// ---------------------------------------------------------------------
// control register 1 bits and vector layout
// ---------------------------------------------------------------------
`define CMIU_BIT_GATE1     0
`define CMIU_BIT_GATE2     1
`define CMIU_BIT_KIND1     2
`define CMIU_BIT_KIND2     3
`define CMIU_BIT_CLEAR     6
`define CMIU_CTRL1_MASK    8'h4F
`define CMIU_VEC_UPPER     8'hFC
`define CMIU_RESET_BYTE    8'h00
`define CMIU_ALL_ONES      8'hFF
`define CMIU_STATIC_FLAG   8'h01

// ---------------------------------------------------------------------
// serial framing
// ---------------------------------------------------------------------
`define CMIU_EDGE_CNT_W    9
`define CMIU_BYTE_DONE     4'hF

`endif

//--- core/cmiu_pkg.sv
/*
 * types shared by the channel match interrupt unit.
 * assumes: compiled before every module of the unit.
 */
package cmiu_pkg;

   // one received slot byte, strobed once per slot
   typedef struct packed {
      logic       strobe;
      logic [4:0] chan;
      logic [7:0] data;
   } cmiu_slot_t;

   // per path settings written by the processor
   typedef struct packed {
      logic [7:0] slot_sel;
      logic [7:0] match;
      logic [7:0] mask;
      logic       kind;
      logic       gate;
   } cmiu_cfg_t;

   // per path state shown to the processor
   typedef struct packed {
      logic [7:0] image;
      logic [7:0] flags;
      logic       pending;
   } cmiu_stat_t;

   typedef enum logic {
      CMIU_WATCH = 1'b0,
      CMIU_HELD  = 1'b1
   } cmiu_state_t;

endpackage : cmiu_pkg

//--- core/cmiu_slot_rx.sv
/*
 * serial slot receiver: counts bit clock falls, shifts the input stream
 * msb first and strobes each completed slot byte with its channel.
 * assumes: bit clock, frame pulse and data are synchronous to core_clk_i
 * and much slower than it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cmiu_regs.svh"

module cmiu_slot_rx
   import cmiu_pkg::*;
#(
   parameter int SLOT_W = 8
) (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       bit_clk_i,
   input  wire logic       frame_n_i,
   input  wire logic       serial_input_stream0_i,
   output var  cmiu_slot_t slot_o
);

   if (SLOT_W != 8) begin : g_chk
      $error("cmiu_slot_rx: only byte wide slots are served");
   end

   logic                         clk_q,   clk_d;
   logic                         arm_q,   arm_d;
   logic [`CMIU_EDGE_CNT_W-1:0]  cnt_q,   cnt_d;
   logic [SLOT_W-1:0]            shift_q, shift_d;
   cmiu_slot_t                   slot_q,  slot_d;
   logic                         fall;

   // ------------------------------------------------------------------
   // bit timing
   // ------------------------------------------------------------------
   always_comb begin
      fall    = clk_q & ~bit_clk_i;
      clk_d   = bit_clk_i;
      arm_d   = arm_q | ~frame_n_i;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      slot_d  = slot_q;
      slot_d.strobe = 1'b0;
      if (fall) begin
         if (arm_q) begin
            cnt_d = '0;
            arm_d = ~frame_n_i;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
         if (!arm_q && cnt_d[0]) begin
            shift_d = {shift_q[SLOT_W-2:0], serial_input_stream0_i};
            if (cnt_d[3:0] == `CMIU_BYTE_DONE) begin
               slot_d.strobe = 1'b1;
               slot_d.chan   = cnt_d[8:4];
               slot_d.data   = shift_d;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_q   <= 1'b0;
         arm_q   <= 1'b0;
         cnt_q   <= '0;
         shift_q <= '0;
         slot_q  <= '0;
      end else begin
         clk_q   <= clk_d;
         arm_q   <= arm_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         slot_q  <= slot_d;
      end
   end

   assign slot_o = slot_q;

endmodule : cmiu_slot_rx
`default_nettype wire

//--- core/cmiu_path.sv
/*
 * one interrupt path: watches the chosen slot, keeps the captured byte,
 * the cause flags and the pending state.
 * assumes: slot strobes come from cmiu_slot_rx; read strobes are one
 * cycle per processor access.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cmiu_regs.svh"

module cmiu_path
   import cmiu_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       active_i,
   input  wire cmiu_slot_t slot_i,
   input  wire cmiu_cfg_t  cfg_i,
   input  wire logic       clear_all_i,
   input  wire logic       rd_image_i,
   input  wire logic       rd_flags_i,
   output var  cmiu_stat_t stat_o
);

   cmiu_state_t  st_q,    st_d;
   logic [7:0]   image_q, image_d;
   logic [7:0]   flags_q, flags_d;
   logic [7:0]   prev_q,  prev_d;
   logic         seen_q,  seen_d;
   logic         hit, stat_match;
   logic [7:0]   rise, fall, cause;

   // ------------------------------------------------------------------
   // detection and servicing
   // ------------------------------------------------------------------
   always_comb begin
      hit = slot_i.strobe && active_i && cfg_i.gate
            && (slot_i.chan == cfg_i.slot_sel[4:0]);
      stat_match = (((slot_i.data ~^ cfg_i.match) | cfg_i.mask)
                    == `CMIU_ALL_ONES);
      rise  = ~prev_q &  slot_i.data;
      fall  =  prev_q & ~slot_i.data;
      cause = (~cfg_i.match &  cfg_i.mask & rise)
            | ( cfg_i.match & ~cfg_i.mask & fall)
            | ( cfg_i.match &  cfg_i.mask & (rise | fall));
      st_d    = st_q;
      image_d = image_q;
      flags_d = flags_q;
      prev_d  = prev_q;
      seen_d  = seen_q;
      if (rd_image_i) begin
         image_d = `CMIU_RESET_BYTE;
         if (!cfg_i.kind) begin
            st_d = CMIU_WATCH;
         end
      end
      if (rd_flags_i) begin
         flags_d = `CMIU_RESET_BYTE;
         if (cfg_i.kind) begin
            st_d = CMIU_WATCH;
         end
      end
      if (hit) begin
         prev_d = slot_i.data;
         seen_d = 1'b1;
         if (st_q == CMIU_WATCH) begin
            image_d = slot_i.data;
            if (!cfg_i.kind && stat_match) begin
               st_d    = CMIU_HELD;
               flags_d = flags_d | `CMIU_STATIC_FLAG;
            end else if (cfg_i.kind && seen_q && cause != '0) begin
               st_d    = CMIU_HELD;
               flags_d = flags_d | cause;
            end
         end
      end
      if (clear_all_i) begin
         st_d    = CMIU_WATCH;
         image_d = `CMIU_RESET_BYTE;
         flags_d = `CMIU_RESET_BYTE;
      end
      stat_o.image   = image_q;
      stat_o.flags   = flags_q;
      stat_o.pending = (st_q == CMIU_HELD);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q    <= CMIU_WATCH;
         image_q <= `CMIU_RESET_BYTE;
         flags_q <= `CMIU_RESET_BYTE;
         prev_q  <= `CMIU_RESET_BYTE;
         seen_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         image_q <= image_d;
         flags_q <= flags_d;
         prev_q  <= prev_d;
         seen_q  <= seen_d;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_held_image_frozen: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (st_q == CMIU_HELD && !rd_image_i && !clear_all_i)
      |=> image_q == $past(image_q))
      else $error("image changed while path held");

   a_static_sets_flag: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (hit && st_q == CMIU_WATCH && !cfg_i.kind && stat_match
       && !clear_all_i)
      |=> flags_q[0] && st_q == CMIU_HELD && image_q == $past(slot_i.data))
      else $error("static match did not raise path");

   a_dyn_flags_cause: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (hit && st_q == CMIU_WATCH && cfg_i.kind && seen_q && cause != '0
       && !clear_all_i && !rd_flags_i)
      |=> (flags_q & $past(cause)) == $past(cause))
      else $error("dynamic cause bits not flagged");

   a_no_event_off: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!active_i && st_q == CMIU_WATCH) |=> st_q == CMIU_WATCH)
      else $error("path raised while inactive");

   a_clear_all_path: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      clear_all_i |=> !stat_o.pending && flags_q == '0 && image_q == '0)
      else $error("clear all left path state");

endmodule : cmiu_path
`default_nettype wire

//--- core/cmiu_top.sv
/*
 * channel match interrupt unit: register file on the parallel bus,
 * two interrupt paths, vector fetch and interrupt request pin.
 * assumes: bus strobes and serial pins are synchronous to core_clk_i;
 * a bus access holds cs_n_i low for at least two clock cycles.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cmiu_regs.svh"

module cmiu_top
   import cmiu_pkg::*;
(
   input  wire logic                    core_clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    mode1_sel_i,
   input  wire logic                    bit_clk_i,
   input  wire logic                    frame_n_i,
   input  wire logic                    serial_input_stream0_i,
   input  wire logic                    cs_n_i,
   input  wire logic                    rw_i,
   input  wire logic [`CMIU_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]              data_i,
   output logic      [7:0]              data_o,
   output logic                         data_oe_o,
   input  wire logic                    vector_fetch_ack_n_i,
   output logic                         irq_n_o
);

   function automatic logic reg_hit(input logic [`CMIU_ADDR_W-1:0] a,
                                    input logic [`CMIU_ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   cmiu_slot_t   slot;
   cmiu_cfg_t    cfg      [2];
   cmiu_stat_t   stat     [2];
   logic [1:0]   rd_image, rd_flags;

   logic [7:0]   ctrl_q,  ctrl_d;
   logic [7:0]   vecu_q,  vecu_d;
   logic [7:0]   sel_q    [2];
   logic [7:0]   sel_d    [2];
   logic [7:0]   match_q  [2];
   logic [7:0]   match_d  [2];
   logic [7:0]   mask_q   [2];
   logic [7:0]   mask_d   [2];
   logic         cs_q,    cs_d;
   logic [7:0]   dout_q,  dout_d;
   logic         irq_q,   irq_d;
   logic         start, rd_start, wr_start, clear_all;
   logic [7:0]   vector, rd_mux;
   logic [1:0]   pend_gated;

   // ------------------------------------------------------------------
   // serial receiver and paths
   // ------------------------------------------------------------------
   cmiu_slot_rx #(
      .SLOT_W (8)
   ) u_rx (
      .core_clk_i             (core_clk_i),
      .rst_i                  (rst_i),
      .bit_clk_i              (bit_clk_i),
      .frame_n_i              (frame_n_i),
      .serial_input_stream0_i (serial_input_stream0_i),
      .slot_o                 (slot)
   );

   for (genvar p = 0; p < 2; p++) begin : g_path
      always_comb begin
         cfg[p].slot_sel = sel_q[p];
         cfg[p].match    = match_q[p];
         cfg[p].mask     = mask_q[p];
         cfg[p].kind     = ctrl_q[`CMIU_BIT_KIND1 + p];
         cfg[p].gate     = ctrl_q[`CMIU_BIT_GATE1 + p];
      end
      cmiu_path u_path (
         .core_clk_i  (core_clk_i),
         .rst_i       (rst_i),
         .active_i    (mode1_sel_i),
         .slot_i      (slot),
         .cfg_i       (cfg[p]),
         .clear_all_i (clear_all),
         .rd_image_i  (rd_image[p]),
         .rd_flags_i  (rd_flags[p]),
         .stat_o      (stat[p])
      );
   end

   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   always_comb begin
      cs_d      = ~cs_n_i;
      start     = ~cs_n_i & ~cs_q;
      rd_start  = start & rw_i;
      wr_start  = start & ~rw_i;
      clear_all = ctrl_q[`CMIU_BIT_CLEAR];
      rd_image  = {rd_start & reg_hit(addr_i, `CMIU_OFF_IMAGE2),
                   rd_start & reg_hit(addr_i, `CMIU_OFF_IMAGE1)};
      rd_flags  = {rd_start & reg_hit(addr_i, `CMIU_OFF_FLAGS2),
                   rd_start & reg_hit(addr_i, `CMIU_OFF_FLAGS1)};
      vector    = (vecu_q & `CMIU_VEC_UPPER)
                | {6'h00, stat[1].pending, stat[0].pending};
      ctrl_d    = ctrl_q;
      ctrl_d[`CMIU_BIT_CLEAR] = 1'b0;
      vecu_d    = vecu_q;
      sel_d     = sel_q;
      match_d   = match_q;
      mask_d    = mask_q;
      if (wr_start) begin
         if (reg_hit(addr_i, `CMIU_OFF_CTRL1)) begin
            ctrl_d = data_i & `CMIU_CTRL1_MASK;
         end
         if (reg_hit(addr_i, `CMIU_OFF_VECTOR)) begin
            vecu_d = data_i & `CMIU_VEC_UPPER;
         end
         for (int p = 0; p < 2; p++) begin
            if (reg_hit(addr_i, `CMIU_OFF_SLOT1 + 6'(p))) begin
               sel_d[p] = data_i;
            end
            if (reg_hit(addr_i, `CMIU_OFF_MATCH1 + 6'(p))) begin
               match_d[p] = data_i;
            end
            if (reg_hit(addr_i, `CMIU_OFF_MASK1 + 6'(p))) begin
               mask_d[p] = data_i;
            end
         end
      end
      case (addr_i)
         `CMIU_OFF_CTRL1:  rd_mux = ctrl_q;
         `CMIU_OFF_VECTOR: rd_mux = vector;
         `CMIU_OFF_FLAGS1: rd_mux = stat[0].flags;
         `CMIU_OFF_FLAGS2: rd_mux = stat[1].flags;
         `CMIU_OFF_IMAGE1: rd_mux = stat[0].image;
         `CMIU_OFF_IMAGE2: rd_mux = stat[1].image;
         `CMIU_OFF_MASK1:  rd_mux = mask_q[0];
         `CMIU_OFF_MASK2:  rd_mux = mask_q[1];
         `CMIU_OFF_MATCH1: rd_mux = match_q[0];
         `CMIU_OFF_MATCH2: rd_mux = match_q[1];
         `CMIU_OFF_SLOT1:  rd_mux = sel_q[0];
         `CMIU_OFF_SLOT2:  rd_mux = sel_q[1];
         default:          rd_mux = `CMIU_RESET_BYTE;
      endcase
   end

   // ------------------------------------------------------------------
   // data bus, vector fetch and request pin
   // ------------------------------------------------------------------
   always_comb begin
      dout_d = dout_q;
      if (!vector_fetch_ack_n_i) begin
         dout_d = vector;
      end else if (rd_start) begin
         dout_d = rd_mux;
      end
      for (int p = 0; p < 2; p++) begin
         pend_gated[p] = stat[p].pending
                       & ctrl_q[`CMIU_BIT_GATE1 + p];
      end
      irq_d     = ~(mode1_sel_i & (|pend_gated));
      data_oe_o = ~vector_fetch_ack_n_i | (~cs_n_i & rw_i);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q  <= `CMIU_RESET_BYTE;
         vecu_q  <= `CMIU_RESET_BYTE;
         for (int p = 0; p < 2; p++) begin
            sel_q[p]   <= `CMIU_RESET_BYTE;
            match_q[p] <= `CMIU_RESET_BYTE;
            mask_q[p]  <= `CMIU_RESET_BYTE;
         end
         cs_q    <= 1'b0;
         dout_q  <= `CMIU_RESET_BYTE;
         irq_q   <= 1'b1;
      end else begin
         ctrl_q  <= ctrl_d;
         vecu_q  <= vecu_d;
         sel_q   <= sel_d;
         match_q <= match_d;
         mask_q  <= mask_d;
         cs_q    <= cs_d;
         dout_q  <= dout_d;
         irq_q   <= irq_d;
      end
   end

   assign data_o  = dout_q;
   assign irq_n_o = irq_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_ack_drives_vector: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!vector_fetch_ack_n_i ##1 !vector_fetch_ack_n_i)
      |-> data_oe_o && data_o == $past(vector))
      else $error("vector not on bus during acknowledge");

   a_clear_self_resets: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      ctrl_q[`CMIU_BIT_CLEAR] |=> !ctrl_q[`CMIU_BIT_CLEAR]
      ##1 vector[1:0] == 2'b00 || $past(slot.strobe))
      else $error("clear all bit stuck or path bits kept");

   a_irq_follows: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (mode1_sel_i && |pend_gated) |=> !irq_n_o)
      else $error("request not raised for pending path");

   a_irq_mode_only: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      !mode1_sel_i |=> irq_n_o)
      else $error("request outside operating mode 1");

   a_vector_low_bits: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      vector[1:0] == {stat[1].pending, stat[0].pending}
      && (vector & ~`CMIU_VEC_UPPER) == {6'h00, vector[1:0]})
      else $error("vector path bits wrong");

   a_vector_write: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_start && addr_i == `CMIU_OFF_VECTOR)
      |=> vecu_q == ($past(data_i) & `CMIU_VEC_UPPER))
      else $error("vector upper bits not stored");

   a_ctrl_write: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_start && addr_i == `CMIU_OFF_CTRL1)
      |=> ctrl_q == ($past(data_i) & `CMIU_CTRL1_MASK))
      else $error("control register write lost");

   a_slot_write: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_start && addr_i == `CMIU_OFF_SLOT1)
      |=> cfg[0].slot_sel == $past(data_i))
      else $error("slot select write lost");

   a_read_oe: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!cs_n_i && rw_i) |-> data_oe_o)
      else $error("read cycle not driving bus");

   a_bus_idle_oe: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (cs_n_i && vector_fetch_ack_n_i) |-> !data_oe_o)
      else $error("bus driven while idle");

   a_data_stands: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!rd_start && vector_fetch_ack_n_i) |=> $stable(data_o))
      else $error("read data changed without access");

   a_image_read_data: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_start && vector_fetch_ack_n_i && addr_i == `CMIU_OFF_IMAGE1)
      |=> data_o == $past(stat[0].image))
      else $error("image read returned wrong byte");

   a_image_read_clr: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_image[0] && !slot.strobe) |=> stat[0].image == '0)
      else $error("image not cleared by read");

   a_flags_read_clr: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_flags[1] && !slot.strobe) |=> stat[1].flags == '0)
      else $error("flags not cleared by read");

   a_static_release: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_image[0] && !cfg[0].kind && !slot.strobe) |=> !stat[0].pending)
      else $error("static path kept after image read");

   a_gate_off_quiet: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!ctrl_q[`CMIU_BIT_GATE1] && !ctrl_q[`CMIU_BIT_GATE2]) |=> irq_n_o)
      else $error("request raised with both paths gated off");

   a_clear_all_vec: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      clear_all |=> vector[1:0] == 2'b00)
      else $error("clear all left vector path bits");

endmodule : cmiu_top
`default_nettype wire

//--- test/cmiu_cpu_model.sv
/* processor model: register and vector fetch cycles on the parallel bus.
   assumes: clk_i is the core clock; rdata_i and oe_i come from the unit. */
`timescale 1ns/1ns
`default_nettype none
module cmiu_cpu_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       oe_i,
   output logic            cs_n_o,
   output logic            rw_o,
   output logic [5:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            ack_n_o
);
   initial begin
      cs_n_o  = 1'b1;
      rw_o    = 1'b1;
      addr_o  = 6'h00;
      wdata_o = 8'h00;
      ack_n_o = 1'b1;
   end
   // one access per select period; reads of image or flags service a path
   task automatic acc(input logic r, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      #1;
      cs_n_o  = 1'b0;
      rw_o    = r;
      addr_o  = a;
      wdata_o = d;
      repeat (2) @(posedge clk_i);
      q = rdata_i;
      #1;
      cs_n_o  = 1'b1;
      wdata_o = ~d;
      @(posedge clk_i);
   endtask : acc
   // vectored acknowledge; skipped by plain register reads elsewhere
   task automatic vec(output logic [7:0] q, output logic oe);
      @(posedge clk_i);
      #1;
      ack_n_o = 1'b0;
      repeat (2) @(posedge clk_i);
      q  = rdata_i;
      oe = oe_i;
      #1;
      ack_n_o = 1'b1;
   endtask : vec
endmodule : cmiu_cpu_model
`default_nettype wire

//--- test/channel_match_interrupt_unit_tb_top.sv
/* self-checking bench of the channel match interrupt unit.
   assumes: cmiu_pkg, cmiu_regs.svh and the core modules compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "cmiu_regs.svh"
module channel_match_interrupt_unit_tb_top;
   logic       clk, rst, m1, bclk, fr_n, sd, cs_n, rw, ack_n, oe, irq_n;
   logic [5:0] addr;
   logic [7:0] wd, rdat;
   int         fail_count;
   int         total_checks;
   cmiu_top u_cmiu_top (.core_clk_i(clk), .rst_i(rst), .mode1_sel_i(m1),
      .bit_clk_i(bclk), .frame_n_i(fr_n), .serial_input_stream0_i(sd),
      .cs_n_i(cs_n), .rw_i(rw), .addr_i(addr), .data_i(wd), .data_o(rdat),
      .data_oe_o(oe), .vector_fetch_ack_n_i(ack_n), .irq_n_o(irq_n));
   cmiu_cpu_model u_cmiu_cpu_model (.clk_i(clk), .rdata_i(rdat), .oe_i(oe),
      .cs_n_o(cs_n), .rw_o(rw), .addr_o(addr), .wdata_o(wd),
      .ack_n_o(ack_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      u_cmiu_cpu_model.acc(1'b1, a, 8'h00, q);
   endtask : rd
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_cmiu_cpu_model.acc(1'b0, a, d, q);
   endtask : wr
   task automatic rdc(string n, logic [5:0] a, logic [7:0] e);
      logic [7:0] q;
      rd(a, q);
      chk(n, e, q);
   endtask : rdc
   task automatic irq(logic e);
      chk("irq_n", {7'h00, e}, {7'h00, irq_n});
   endtask : irq
   // frame up to channel ch; bits go out msb first on odd falls
   task automatic frame(input logic [4:0] ch, input logic [7:0] b);
      int e;
      @(posedge clk);
      #1;
      fr_n = 1'b0;
      bclk = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      bclk = 1'b0;
      fr_n = 1'b1;
      for (e = 1; e <= ch * 16 + 15; e++) begin
         repeat (6) @(posedge clk);
         #1;
         bclk = 1'b1;
         sd = (e[0] && e[8:4] == ch) ? b[7 - e[3:1]] : e[1];
         repeat (6) @(posedge clk);
         #1;
         bclk = 1'b0;
      end
      repeat (8) @(posedge clk);
      #1;
      sd = ~sd;
   endtask : frame
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_static;
      logic [7:0] q;
      logic       o;
      wr(`CMIU_OFF_SLOT1, 8'h02);
      wr(`CMIU_OFF_MATCH1, 8'hA0);
      wr(`CMIU_OFF_MASK1, 8'h0F);
      wr(`CMIU_OFF_VECTOR, 8'h87);
      wr(`CMIU_OFF_CTRL1, 8'h01);
      frame(5'd2, 8'h53);
      irq(1'b1);
      rdc("image1", `CMIU_OFF_IMAGE1, 8'h53);
      rdc("image1 clr", `CMIU_OFF_IMAGE1, 8'h00);
      frame(5'd2, 8'hA6);
      irq(1'b0);
      u_cmiu_cpu_model.vec(q, o);
      chk("vector", 8'h85, q);
      chk("oe", 8'h01, {7'h00, o});
      rdc("flags1", `CMIU_OFF_FLAGS1, 8'h01);
      frame(5'd2, 8'hA9);
      rdc("image1 held", `CMIU_OFF_IMAGE1, 8'hA6);
      irq(1'b1);
      rdc("vector idle", `CMIU_OFF_VECTOR, 8'h84);
      $display("static test done");
   endtask : t_static
   task automatic t_dynamic;
      wr(`CMIU_OFF_SLOT2, 8'h03);
      wr(`CMIU_OFF_MATCH2, 8'h00);
      wr(`CMIU_OFF_MASK2, 8'h08);
      wr(`CMIU_OFF_CTRL1, 8'h0A);
      frame(5'd3, 8'h08);
      frame(5'd3, 8'h00);
      irq(1'b1);
      frame(5'd3, 8'hF8);
      irq(1'b0);
      rdc("vector", `CMIU_OFF_VECTOR, 8'h86);
      rdc("image2", `CMIU_OFF_IMAGE2, 8'hF8);
      rdc("flags2", `CMIU_OFF_FLAGS2, 8'h08);
      irq(1'b1);
      wr(`CMIU_OFF_MATCH2, 8'h08);
      wr(`CMIU_OFF_MASK2, 8'h08);
      frame(5'd3, 8'h00);
      rdc("flags2 any", `CMIU_OFF_FLAGS2, 8'h08);
      wr(`CMIU_OFF_MASK2, 8'h00);
      frame(5'd3, 8'h08);
      irq(1'b1);
      frame(5'd3, 8'h00);
      rdc("flags2 fall", `CMIU_OFF_FLAGS2, 8'h08);
      $display("dynamic test done");
   endtask : t_dynamic
   task automatic t_clear;
      wr(`CMIU_OFF_CTRL1, 8'h01);
      frame(5'd2, 8'hA1);
      irq(1'b0);
      wr(`CMIU_OFF_CTRL1, 8'h41);
      repeat (4) @(posedge clk);
      #1;
      irq(1'b1);
      rdc("ctrl1", `CMIU_OFF_CTRL1, 8'h01);
      rdc("flags1", `CMIU_OFF_FLAGS1, 8'h00);
      rdc("image1", `CMIU_OFF_IMAGE1, 8'h00);
      rdc("vector", `CMIU_OFF_VECTOR, 8'h84);
      #1;
      m1 = 1'b0;
      frame(5'd2, 8'hA1);
      irq(1'b1);
      m1 = 1'b1;
      rdc("image1 off", `CMIU_OFF_IMAGE1, 8'h00);
      wr(`CMIU_OFF_CTRL1, 8'h00);
      frame(5'd2, 8'hA1);
      irq(1'b1);
      rdc("unmapped", 6'h3F, 8'h00);
      $display("clear and gate test done");
   endtask : t_clear
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   initial begin
      fail_count   = 0;
      total_checks = 0;
      rst  = 1'b1;
      m1   = 1'b1;
      bclk = 1'b0;
      fr_n = 1'b1;
      sd   = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      t_static;
      t_dynamic;
      t_clear;
      test_done;
   end
endmodule : channel_match_interrupt_unit_tb_top
`default_nettype wire
